/* hw/tvcd_params.svh */
// Constants for the TV character display timing block
`ifndef TVCD_PARAMS_SVH
`define TVCD_PARAMS_SVH

// ==========================================================
// Register map (byte offsets) and fields
`define TVCD_REG_DATA     4'h0
`define TVCD_REG_CTRL     4'h4
`define TVCD_REG_STATUS   4'h8
`define TVCD_CTRL_INVERT  0
`define TVCD_CTRL_EXTSEL  1
`define TVCD_STAT_BUSY    16
`define TVCD_STAT_VBLANK  17
`define TVCD_CTRL_RESET   2'h0
`define TVCD_HOME_CODE    7'h7F

// ==========================================================
// Rates and times as specified
`define TVCD_SYS_HZ       100000000
`define TVCD_DOT_HZ       11980000
`define TVCD_LINE_HZ      15598
`define TVCD_FRAME_HZ     60
`define TVCD_HSYNC_NS     8000
`define TVCD_HBLANK_NS    20000
`define TVCD_VSYNC_US     820
`define TVCD_VBLANK_US    3500
`define TVCD_WR_SETUP_NS  600
`define TVCD_WR_PULSE_NS  600

// ==========================================================
// Derived counts: dots per line, lines per frame, cycles
`define TVCD_HTOTAL ((`TVCD_DOT_HZ + `TVCD_LINE_HZ / 2) / `TVCD_LINE_HZ)
`define TVCD_HSYNC_DOTS ((`TVCD_HSYNC_NS * (`TVCD_DOT_HZ / 1000)) / 1000000)
`define TVCD_HBLANK_DOTS ((`TVCD_HBLANK_NS * (`TVCD_DOT_HZ / 1000)) / 1000000)
`define TVCD_VTOTAL ((`TVCD_LINE_HZ + `TVCD_FRAME_HZ / 2) / `TVCD_FRAME_HZ)
`define TVCD_VSYNC_LINES ((`TVCD_VSYNC_US * `TVCD_LINE_HZ) / 1000000)
`define TVCD_VBLANK_LINES ((`TVCD_VBLANK_US * `TVCD_LINE_HZ) / 1000000)
`define TVCD_WR_SETUP_CYC \
  ((`TVCD_WR_SETUP_NS * (`TVCD_SYS_HZ / 1000000) + 999) / 1000)
`define TVCD_WR_PULSE_CYC \
  ((`TVCD_WR_PULSE_NS * (`TVCD_SYS_HZ / 1000000) + 999) / 1000)

`endif

/* hw/tvcd_pkg.sv */
// Types shared by the TV character display timing block
package tvcd_pkg;

  // Write sequencer states, one-hot
  typedef enum logic [2:0] {
    WS_IDLE   = 3'b001,
    WS_SETUP  = 3'b010,
    WS_STROBE = 3'b100
  } tvcd_wr_state_type;

  // Host input lines: strobe plus seven character lines
  typedef struct packed {
    logic       strobe;
    logic [6:0] chr;
  } tvcd_inlines_type;

  // Digital video group toward the output driver
  typedef struct packed {
    logic pixel;
    logic hsyncN;
    logic vsyncN;
    logic blanking;
  } tvcd_video_type;

endpackage

/* hw/tvcd_display.sv */
// Character memory, scan timing, entry logic and Avalon slave
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "tvcd_params.svh"

module tvcd_display #(
  parameter int COLS      = 64,
  parameter int TEXT_ROWS = 16,
  parameter int SCAN_ROWS = 13
) (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic [3:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic                    hResetN,
  input  wire logic                    vResetN,
  input  wire logic                    extVideo,
  output logic [6:0]                   fontChar,
  output logic [3:0]                   fontRow,
  input  wire logic [6:0]              fontDots,
  output tvcd_pkg::tvcd_video_type     video
);

  // ==========================================================
  // Elaboration checks and local counts
  generate
    if (COLS != 64 || TEXT_ROWS != 16 || SCAN_ROWS != 13) begin : g_chk
      $error("tvcd_display: only a 64 x 16 screen of 13-row cells");
    end
  endgenerate

  localparam logic [9:0] HTOTAL   = 10'(`TVCD_HTOTAL);
  localparam logic [9:0] HSYNC    = 10'(`TVCD_HSYNC_DOTS);
  localparam logic [9:0] HBLANK   = 10'(`TVCD_HBLANK_DOTS);
  localparam logic [9:0] HACTIVE  = HTOTAL - HBLANK;
  localparam logic [9:0] HSYNC_ST = HACTIVE + (HBLANK - HSYNC) / 10'd2;
  localparam logic [8:0] VTOTAL   = 9'(`TVCD_VTOTAL);
  localparam logic [8:0] VSYNC    = 9'(`TVCD_VSYNC_LINES);
  localparam logic [8:0] VBLANK   = 9'(`TVCD_VBLANK_LINES);
  localparam logic [8:0] VACTIVE  = VTOTAL - VBLANK;
  localparam logic [8:0] VSYNC_ST = VACTIVE + (VBLANK - VSYNC) / 9'd2;
  localparam logic [6:0] CELLS    = 7'(`TVCD_HTOTAL / 8);
  localparam logic [6:0] SETUP_C  = 7'(`TVCD_WR_SETUP_CYC);
  localparam logic [6:0] PULSE_C  = 7'(`TVCD_WR_PULSE_CYC);
  localparam logic [26:0] DOT_INC = 27'(`TVCD_DOT_HZ);
  localparam logic [26:0] SYS_HZ  = 27'(`TVCD_SYS_HZ);

  // ==========================================================
  // Dot rate enable: fractional divider keeps the exact mean rate
  logic [26:0] dotAcc_ff;
  logic [26:0] nxt_dotAcc;
  logic        dotEn_ff;

  always_comb begin
    nxt_dotAcc = dotAcc_ff + DOT_INC;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dotAcc_ff <= 27'h0000000;
      dotEn_ff  <= 1'b0;
    end else if (nxt_dotAcc >= SYS_HZ) begin
      dotAcc_ff <= nxt_dotAcc - SYS_HZ;
      dotEn_ff  <= 1'b1;
    end else begin
      dotAcc_ff <= nxt_dotAcc;
      dotEn_ff  <= 1'b0;
    end
  end

  // ==========================================================
  // Pin synchronisers; edge detectors compare the second and third stages
  logic [2:0] hRstSh_ff;
  logic [2:0] vRstSh_ff;
  logic [1:0] extSh_ff;
  logic       hRstFall;
  logic       vRstFall;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hRstSh_ff <= 3'h7;
      vRstSh_ff <= 3'h7;
      extSh_ff  <= 2'h0;
    end else begin
      hRstSh_ff <= {hRstSh_ff[1:0], hResetN};
      vRstSh_ff <= {vRstSh_ff[1:0], vResetN};
      extSh_ff  <= {extSh_ff[0], extVideo};
    end
  end

  assign hRstFall = hRstSh_ff[2] & ~hRstSh_ff[1];
  assign vRstFall = vRstSh_ff[2] & ~vRstSh_ff[1];

  // ==========================================================
  // Horizontal and vertical chains with scan row tracking
  logic [9:0] hCount_ff;
  logic [8:0] vCount_ff;
  logic [3:0] scanRow_ff;
  logic [4:0] textRow_ff;
  logic       lineEnd;
  logic [8:0] nxt_vCount;
  logic [3:0] nxt_scanRow;
  logic [4:0] nxt_textRow;

  assign lineEnd = dotEn_ff && (hCount_ff == HTOTAL - 10'd1);

  // Next line values, shared by the chain and the prefetch
  always_comb begin
    nxt_vCount  = vCount_ff + 9'd1;
    nxt_scanRow = scanRow_ff + 4'd1;
    nxt_textRow = textRow_ff;
    if (vCount_ff == VTOTAL - 9'd1) begin
      nxt_vCount  = 9'h000;
      nxt_scanRow = 4'h0;
      nxt_textRow = 5'h00;
    end else if (scanRow_ff == 4'(SCAN_ROWS - 1)) begin
      nxt_scanRow = 4'h0;
      nxt_textRow = textRow_ff + 5'd1;
    end
  end

  // Line counter; outside reset clears it at once
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hCount_ff <= 10'h000;
    end else if (hRstFall) begin
      hCount_ff <= 10'h000;
    end else if (lineEnd) begin
      hCount_ff <= 10'h000;
    end else if (dotEn_ff) begin
      hCount_ff <= hCount_ff + 10'd1;
    end
  end

  // Frame counter and the current scan row of the character
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      vCount_ff  <= 9'h000;
      scanRow_ff <= 4'h0;
      textRow_ff <= 5'h00;
    end else if (vRstFall) begin
      vCount_ff  <= 9'h000;
      scanRow_ff <= 4'h0;
      textRow_ff <= 5'h00;
    end else if (lineEnd) begin
      vCount_ff  <= nxt_vCount;
      scanRow_ff <= nxt_scanRow;
      textRow_ff <= nxt_textRow;
    end
  end

  // ==========================================================
  // Host input lines, control register and edge decoding
  tvcd_pkg::tvcd_inlines_type inLines_ff;
  tvcd_pkg::tvcd_inlines_type newLines;
  tvcd_pkg::tvcd_wr_state_type wrState_ff;
  logic [1:0]  ctrl_ff;
  logic [9:0]  entry_ff;
  logic        waitReq_ff;
  logic        accept;
  logic        dataWr;
  logic        wrBusy;
  logic        homeCmd;
  logic        startWr;
  logic        stepFwd;
  logic        stepBack;
  logic        wrDone;
  logic        wrFire;

  assign wrBusy   = (wrState_ff != tvcd_pkg::WS_IDLE);
  assign accept   = avs_write && !waitReq_ff;
  assign dataWr   = accept && (avs_address == `TVCD_REG_DATA)
                    && avs_byteenable[0];
  assign newLines = avs_writedata[7:0];
  // Each control acts only on a rising edge of its line
  assign homeCmd  = dataWr && (newLines.chr == `TVCD_HOME_CODE)
                    && (inLines_ff.chr != `TVCD_HOME_CODE);
  assign startWr  = dataWr && !homeCmd && newLines.strobe
                    && !inLines_ff.strobe;
  assign stepFwd  = dataWr && !homeCmd && !newLines.strobe
                    && newLines.chr[0] && !inLines_ff.chr[0];
  assign stepBack = dataWr && !homeCmd && !newLines.strobe && !stepFwd
                    && newLines.chr[1] && !inLines_ff.chr[1];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      inLines_ff <= 8'h00;
    end else if (dataWr) begin
      inLines_ff <= newLines;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `TVCD_CTRL_RESET;
    end else if (accept && (avs_address == `TVCD_REG_CTRL)
                 && avs_byteenable[0]) begin
      ctrl_ff <= avs_writedata[1:0];
    end
  end

  // ==========================================================
  // Write sequencer: character grab, setup wait, then write pulse
  logic [6:0] phase_ff;
  logic [6:0] wrChar_ff;

  assign wrFire = (wrState_ff == tvcd_pkg::WS_STROBE)
                  && (phase_ff == 7'h00);
  assign wrDone = (wrState_ff == tvcd_pkg::WS_STROBE)
                  && (phase_ff == PULSE_C - 7'd1);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wrState_ff <= tvcd_pkg::WS_IDLE;
      phase_ff   <= 7'h00;
      wrChar_ff  <= 7'h00;
    end else begin
      case (wrState_ff)
        tvcd_pkg::WS_IDLE: begin
          if (startWr) begin
            wrState_ff <= tvcd_pkg::WS_SETUP;
            phase_ff   <= 7'h00;
            wrChar_ff  <= newLines.chr;
          end
        end
        tvcd_pkg::WS_SETUP: begin
          if (phase_ff == SETUP_C - 7'd1) begin
            wrState_ff <= tvcd_pkg::WS_STROBE;
            phase_ff   <= 7'h00;
          end else begin
            phase_ff <= phase_ff + 7'd1;
          end
        end
        tvcd_pkg::WS_STROBE: begin
          if (wrDone) begin
            wrState_ff <= tvcd_pkg::WS_IDLE;
            phase_ff   <= 7'h00;
          end else begin
            phase_ff <= phase_ff + 7'd1;
          end
        end
        default: begin
          wrState_ff <= tvcd_pkg::WS_IDLE;
          phase_ff   <= 7'h00;
        end
      endcase
    end
  end

  // Entry counter; a 10-bit count wraps after the last cell by itself
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      entry_ff <= 10'h000;
    end else if (homeCmd) begin
      entry_ff <= 10'h000;
    end else if (wrDone || stepFwd) begin
      entry_ff <= entry_ff + 10'd1;
    end else if (stepBack) begin
      entry_ff <= entry_ff - 10'd1;
    end
  end

  // ==========================================================
  // Character memory and display prefetch
  logic [6:0] charMem [0:1023];
  logic [6:0] fetchCol;
  logic       fetchWraps;
  logic [4:0] fetchText;
  logic [3:0] fetchScan;
  logic [9:0] dispAddr_ff;
  logic       fetchOn_ff;
  logic       fetchOnD_ff;
  logic [9:0] memAddr;

  // Storage has no reset; contents are random until written
  always_ff @(posedge clock) begin
    if (wrFire) begin
      charMem[entry_ff] <= wrChar_ff;
    end
  end

  // Entry address wins the memory while a write is pending
  assign memAddr = wrBusy ? entry_ff : dispAddr_ff;

  // Prefetch targets the next cell, crossing into the next line
  assign fetchWraps = (hCount_ff[9:3] + 7'd1) == CELLS;
  assign fetchCol   = fetchWraps ? 7'h00 : hCount_ff[9:3] + 7'd1;
  assign fetchText  = fetchWraps ? nxt_textRow : textRow_ff;
  assign fetchScan  = fetchWraps ? nxt_scanRow : scanRow_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dispAddr_ff <= 10'h000;
      fetchOn_ff  <= 1'b0;
      fontRow     <= 4'h0;
    end else if (dotEn_ff && hCount_ff[2:0] == 3'd3) begin
      dispAddr_ff <= {fetchText[3:0], fetchCol[5:0]};
      fetchOn_ff  <= (fetchCol < 7'(COLS))
                     && (fetchText < 5'(TEXT_ROWS));
      fontRow     <= fetchScan;
    end
  end

  // Character code to the font lookup, one cycle after the address
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fontChar    <= 7'h00;
      fetchOnD_ff <= 1'b0;
    end else begin
      fontChar    <= charMem[memAddr];
      fetchOnD_ff <= fetchOn_ff;
    end
  end

  // ==========================================================
  // Dot serialiser: seven font dots then one blank space dot
  logic [7:0] shift_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shift_ff <= 8'h00;
    end else if (dotEn_ff && hCount_ff[2:0] == 3'd7) begin
      shift_ff <= fetchOnD_ff ? {fontDots, 1'b0} : 8'h00;
    end else if (dotEn_ff) begin
      shift_ff <= {shift_ff[6:0], 1'b0};
    end
  end

  // ==========================================================
  // Video, sync and blanking outputs
  logic hBlank;
  logic vBlank;
  logic hSyncOn;
  logic vSyncOn;
  logic srcDot;

  assign hBlank  = hCount_ff >= HACTIVE;
  assign vBlank  = vCount_ff >= VACTIVE;
  assign hSyncOn = (hCount_ff >= HSYNC_ST)
                   && (hCount_ff < HSYNC_ST + HSYNC);
  assign vSyncOn = (vCount_ff >= VSYNC_ST)
                   && (vCount_ff < VSYNC_ST + VSYNC);
  assign srcDot  = ctrl_ff[`TVCD_CTRL_EXTSEL] ? extSh_ff[1] : shift_ff[7];

  // Blank during writes hides memory glitches at the cost of a flicker
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      video <= 4'h0;
    end else begin
      video.blanking <= hBlank || vBlank || wrBusy;
      video.pixel    <= !(hBlank || vBlank || wrBusy)
                        && (srcDot ^ ctrl_ff[`TVCD_CTRL_INVERT]);
      video.hsyncN   <= !hSyncOn;
      video.vsyncN   <= !vSyncOn;
    end
  end

  // ==========================================================
  // Avalon slave: one wait cycle, data writes stall while busy
  logic [31:0] regRead;
  logic        hold;

  assign hold = avs_write && (avs_address == `TVCD_REG_DATA) && wrBusy;

  always_comb begin
    regRead = 32'h00000000;
    case (avs_address)
      `TVCD_REG_DATA:   regRead[7:0] = inLines_ff;
      `TVCD_REG_CTRL:   regRead[1:0] = ctrl_ff;
      `TVCD_REG_STATUS: begin
        regRead[9:0]              = entry_ff;
        regRead[`TVCD_STAT_BUSY]   = wrBusy;
        regRead[`TVCD_STAT_VBLANK] = vBlank;
      end
      default:          regRead = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      waitReq_ff   <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if ((avs_read || avs_write) && waitReq_ff && !hold) begin
      waitReq_ff <= 1'b0;
      if (avs_read) begin
        avs_readdata <= regRead;
      end
    end else begin
      waitReq_ff <= 1'b1;
    end
  end

  assign avs_waitrequest = waitReq_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  mem_store_a: assert property (
    wrFire |=> charMem[$past(entry_ff)] == $past(wrChar_ff))
    else $error("character not stored at entry address");
  strobe_delay_a: assert property (
    $rose(wrState_ff == tvcd_pkg::WS_STROBE)
      |-> $past(wrState_ff == tvcd_pkg::WS_SETUP, 60))
    else $error("write pulse not 600 ns after strobe");
  write_blank_a: assert property (
    startWr |=> ##1 (video.blanking && !video.pixel) [*8])
    else $error("video not blanked during write");
  home_preset_a: assert property (
    homeCmd |=> entry_ff == 10'h000 && !wrBusy)
    else $error("home did not preset entry address");
  step_fwd_a: assert property (
    stepFwd |=> entry_ff == $past(entry_ff) + 10'd1 && !wrBusy)
    else $error("forward step wrong or wrote");
  step_back_a: assert property (
    stepBack |=> entry_ff == $past(entry_ff) - 10'd1 && !wrBusy)
    else $error("back step wrong or wrote");
  addr_prio_a: assert property (
    wrBusy |-> ##1 fontChar === $past(charMem[entry_ff]))
    else $error("entry address lost memory priority");
  entry_wrap_a: assert property (
    wrDone && entry_ff == 10'h3FF |=> entry_ff == 10'h000)
    else $error("entry address did not wrap");
  line_wrap_a: assert property (
    lineEnd && !hRstFall |=> hCount_ff == 10'h000
      && $past(hCount_ff) == 10'd767)
    else $error("line length not 768 dots");
  hsync_end_a: assert property (
    hRstFall |=> ##1 video.hsyncN)
    else $error("outside reset did not end horizontal sync");
  space_dot_a: assert property (
    dotEn_ff && hCount_ff[2:0] == 3'd7 |=> shift_ff[0] == 1'b0)
    else $error("eighth dot not blank");

endmodule
`default_nettype wire

/* verification/tvcd_font_model.sv */
// Behavioural font ROM partner that answers the display's glyph lookups
`timescale 1ns/100ps
`default_nettype none

module tvcd_font_model (
  input  wire logic [6:0] fontChar,
  input  wire logic [3:0] fontRow,
  output logic      [6:0] fontDots
);
  // ==========================================================
  // Lookup
  // Answers at once, with a pattern that depends on code and row, so
  // that a swapped row or code gives different dots
  assign fontDots = fontChar ^ {3'h0, fontRow};
endmodule

`default_nettype wire

/* verification/tv_character_display_timing_tb_top.sv */
// Self-checking testbench for the TV character display block
`timescale 1ns/100ps
`default_nettype none
`include "tvcd_params.svh"

module tv_character_display_timing_tb_top;
  logic                   clock;
  logic                   rst;
  logic [3:0]             avs_address;
  logic                   avs_read;
  logic                   avs_write;
  logic [31:0]            avs_writedata;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic                   hResetN;
  logic                   vResetN;
  logic                   extVideo;
  logic [6:0]             fontChar;
  logic [3:0]             fontRow;
  logic [6:0]             fontDots;
  tvcd_pkg::tvcd_video_type video;
  int                     failures;
  int                     n_tests;
  logic [31:0]            q;
  int                     n;
  int                     w;
  // ==========================================================
  // Ordinary cases: byte written to the data port, entry address after
  localparam logic [7:0] ROW_DATA [15] = '{8'h7F, 8'h00, 8'hC1, 8'h00,
    8'h01, 8'h01, 8'h00, 8'h02, 8'h00, 8'h02, 8'h00, 8'h02, 8'h00,
    8'hA0, 8'h00};
  localparam logic [9:0] ROW_ENTRY [15] = '{10'h000, 10'h000, 10'h001,
    10'h001, 10'h002, 10'h002, 10'h002, 10'h001, 10'h001, 10'h000,
    10'h000, 10'h3FF, 10'h3FF, 10'h000, 10'h000};

  // ==========================================================
  // Design and partner
  tvcd_display uut (
    .clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .hResetN(hResetN), .vResetN(vResetN), .extVideo(extVideo),
    .fontChar(fontChar), .fontRow(fontRow), .fontDots(fontDots),
    .video(video)
  );
  tvcd_font_model font (
    .fontChar(fontChar), .fontRow(fontRow), .fontDots(fontDots)
  );

  // Free-running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================================
  // Shared tasks
  task automatic wrap_up();
    if (failures == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] adr,
                     input logic [31:0] wd, output logic [31:0] rd);
    int i;
    @(posedge clock);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    for (i = 0; i < 400; i++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 400) begin
      failures++;
      wrap_up();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Polls status until the write sequencer is idle
  task automatic waitIdle(output logic [31:0] st);
    int k;
    for (k = 0; k < 100; k++) begin
      bus(1'b0, `TVCD_REG_STATUS, 32'h0, st);
      if (st[`TVCD_STAT_BUSY] === 1'b0) break;
    end
    if (k == 100) begin
      failures++;
      wrap_up();
    end
  endtask

  // Cycles until hsync (sel 0) or blanking (sel 1) reaches lvl
  task automatic span(input int sel, input logic lvl, output int cnt);
    cnt = 0;
    while (((sel == 0) ? video.hsyncN : video.blanking) !== lvl) begin
      @(posedge clock);
      cnt++;
      if (cnt > 9000) begin
        failures++;
        wrap_up();
      end
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    failures = 0;
    n_tests = 0;
    rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    hResetN = 1'b1;
    vResetN = 1'b1;
    extVideo = 1'b0;
    repeat (15) @(posedge clock);
    #1;
    chk({31'h0, avs_waitrequest}, 32'h1);
    chk(avs_readdata, 32'h0);
    chk({21'h0, fontChar, fontRow}, 32'h0);
    chk({28'h0, video}, 32'h0);
    @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, `TVCD_REG_CTRL, 32'h0, q);
    chk(q & 32'h3, 32'h0);
    bus(1'b1, 4'hC, 32'hFFFF_FFFF, q);
    bus(1'b0, 4'hC, 32'h0, q);
    chk(q, 32'h0);
    // Table of entry-address cases
    for (int r = 0; r < 15; r++) begin
      bus(1'b1, `TVCD_REG_DATA, {24'h0, ROW_DATA[r]}, q);
      waitIdle(q);
      chk({22'h0, q[9:0]}, {22'h0, ROW_ENTRY[r]});
    end
    // A strobe marks the sequencer busy and blanks the picture
    bus(1'b1, `TVCD_REG_DATA, 32'hC2, q);
    bus(1'b0, `TVCD_REG_STATUS, 32'h0, q);
    chk({31'h0, q[`TVCD_STAT_BUSY]}, 32'h1);
    chk({31'h0, video.blanking}, 32'h1);
    bus(1'b1, `TVCD_REG_DATA, 32'h00, q);
    // Line timing in system clocks; blank measured from its own start,
    // since sync already sits inside the blank
    span(0, 1'b0, n);
    span(0, 1'b1, w);
    chk({31'h0, (w >= 788 && w <= 812)}, 32'h1);
    span(1, 1'b0, n);
    span(1, 1'b1, n);
    span(1, 1'b0, w);
    chk({31'h0, (w >= 1980 && w <= 2020)}, 32'h1);
    chk({31'h0, (w + n >= 6403 && w + n <= 6419)}, 32'h1);
    // External video selected, then inverted, inside the visible area
    extVideo <= 1'b1;
    bus(1'b1, `TVCD_REG_CTRL, 32'h2, q);
    repeat (6) @(posedge clock);
    chk({31'h0, video.pixel}, 32'h1);
    bus(1'b1, `TVCD_REG_CTRL, 32'h3, q);
    repeat (6) @(posedge clock);
    chk({31'h0, video.pixel}, 32'h0);
    bus(1'b0, `TVCD_REG_CTRL, 32'h0, q);
    chk(q & 32'h3, 32'h3);
    bus(1'b1, `TVCD_REG_CTRL, 32'h0, q);
    // Outside line reset ends sync and restarts the line
    span(0, 1'b0, n);
    repeat (100) @(posedge clock);
    hResetN <= 1'b0;
    repeat (3) @(posedge clock);
    hResetN <= 1'b1;
    span(0, 1'b1, w);
    chk({31'h0, (w <= 12)}, 32'h1);
    span(0, 1'b0, n);
    chk({31'h0, (n + w >= 4995 && n + w <= 5040)}, 32'h1);
    // Outside frame reset: row 1 on the next line proves a known state,
    // then a second pulse must pull that row back to 0
    vResetN <= 1'b0;
    repeat (3) @(posedge clock);
    vResetN <= 1'b1;
    repeat (10) @(posedge clock);
    bus(1'b0, `TVCD_REG_STATUS, 32'h0, q);
    chk({31'h0, q[`TVCD_STAT_VBLANK]}, 32'h0);
    span(1, 1'b0, n);
    repeat (100) @(posedge clock);
    chk({28'h0, fontRow}, 32'h1);
    vResetN <= 1'b0;
    repeat (3) @(posedge clock);
    vResetN <= 1'b1;
    repeat (100) @(posedge clock);
    chk({28'h0, fontRow}, 32'h0);
    // Clear of the top eight text rows: home, then 512 spaces
    bus(1'b1, `TVCD_REG_DATA, 32'h7F, q);
    for (int j = 0; j < 512; j++) begin
      bus(1'b1, `TVCD_REG_DATA, 32'hA0, q);
      bus(1'b1, `TVCD_REG_DATA, 32'h00, q);
    end
    waitIdle(q);
    chk({22'h0, q[9:0]}, 32'h200);
    wrap_up();
  end

  // Hang guard
  initial begin
    repeat (99000) @(posedge clock);
    failures++;
    wrap_up();
  end
endmodule

`default_nettype wire
